// File: design/bsc_cond_eval.sv
// Branch condition evaluator for the execution unit.
// Assumes the flag byte uses the bit positions named in bsc_pkg.
`timescale 1ns/1ps
module bsc_cond_eval
(
	// Condition select and flags
	input  logic [3:0] cond,
	input  logic [7:0] flags,
	// Result
	output logic       taken
);

	logic base;
	logic c_f;
	logic v_f;
	logic z_f;
	logic n_f;

	// ==========================================================
	// Evaluation
	always_comb
	begin
		c_f = flags[bsc_pkg::CC_C];
		v_f = flags[bsc_pkg::CC_V];
		z_f = flags[bsc_pkg::CC_Z];
		n_f = flags[bsc_pkg::CC_N];
		case ({cond[3:1], 1'b0})
			bsc_pkg::CND_ALWAYS: base = 1'b1;
			bsc_pkg::CND_HI:     base = ~(c_f | z_f);
			bsc_pkg::CND_CC:     base = ~c_f;
			bsc_pkg::CND_NE:     base = ~z_f;
			bsc_pkg::CND_VC:     base = ~v_f;
			bsc_pkg::CND_PL:     base = ~n_f;
			bsc_pkg::CND_GE:     base = ~(n_f ^ v_f);
			bsc_pkg::CND_GT:     base = ~(z_f | (n_f ^ v_f));
			default:             base = 1'b0;
		endcase
		// The odd code of each pair tests the opposite outcome.
		taken = base ^ cond[0];
	end

endmodule

// File: design/bsc_exec_unit.sv
// Execution unit for branches, calls, returns, flag byte operations, power-down entry and block move.
// Assumes an Avalon-MM master on the same clock; instructions are issued by writing the command register.
//
// How it works
// - Conditional branch jumps only when condition holds.
// - Unsigned, zero, overflow, negative tests use flags.
// - Unconditional jump always loads the target.
// - Calls jump and push a return point.
// - Exception return restores flags and program counter.
// - Power-down entry leaves active mode, configured mode.
// - Flag load takes immediate or general register.
// - Flag store copies flags to general register.
// - Flag AND with immediate byte.
// - Flag OR with immediate byte.
// - Flag XOR with immediate byte.
// - No-operation only advances program counter by two.
// - Block move copies count bytes, post-increments pointers.
// - Block move stalls following instructions until done.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module bsc_exec_unit
(
	// Clock and reset
	input  logic        core_clk,
	input  logic        nrst,
	// Avalon-MM slave
	input  logic [7:0]  avs_address,
	input  logic        avs_read,
	input  logic        avs_write,
	input  logic [31:0] avs_writedata,
	input  logic [3:0]  avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic        avs_waitrequest,
	// Power-down state
	output logic        power_down,
	output logic [1:0]  power_down_mode
);

	typedef logic [7:0]  bsc_byte_t;
	typedef logic [15:0] bsc_word_t;

	// ==========================================================
	// State
	bsc_pkg::bsc_state_t state_r, state_nxt;
	logic [3:0]  op_r, op_nxt;
	logic [3:0]  cond_r, cond_nxt;
	bsc_word_t   opnd_r, opnd_nxt;
	bsc_word_t   pc_r, pc_nxt;
	bsc_word_t   sp_r, sp_nxt;
	bsc_byte_t   cc_r, cc_nxt;
	bsc_byte_t   greg_r, greg_nxt;
	bsc_byte_t   cnt_r, cnt_nxt;
	bsc_word_t   src_r, src_nxt;
	bsc_word_t   dst_r, dst_nxt;
	bsc_byte_t   maddr_r, maddr_nxt;
	bsc_byte_t   lo_r, lo_nxt;
	logic        pdown_r, pdown_nxt;
	logic [1:0]  pmode_r, pmode_nxt;
	logic [1:0]  pcfg_r, pcfg_nxt;
	logic        wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	localparam int unsigned MEM_DEPTH_L = bsc_pkg::MEM_DEPTH;

	bsc_byte_t   mem [MEM_DEPTH_L];

	logic        busy;
	logic        wr_do;
	logic        cond_true;
	logic        mem_we;
	bsc_byte_t   mem_wa;
	bsc_byte_t   mem_wd;
	bsc_word_t   ret_addr;
	bsc_word_t   pop_ret;
	bsc_word_t   pop_exc_pc;
	bsc_byte_t   pop_cc;

	// ==========================================================
	// Helpers
	function automatic bsc_byte_t idx(input bsc_word_t base, input bsc_byte_t off);
		idx = base[7:0] + off;
	endfunction

	function automatic bsc_word_t merge16(input bsc_word_t old, input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic bsc_byte_t merge8(input bsc_byte_t old, input logic [31:0] wd, input logic [3:0] be);
		merge8 = be[0] ? wd[7:0] : old;
	endfunction

	bsc_cond_eval u_cond
	(
		.cond  (cond_r),
		.flags (cc_r),
		.taken (cond_true)
	);

	assign busy       = (state_r != bsc_pkg::S_IDLE) && (state_r != bsc_pkg::S_SLEEP);
	assign wr_do      = avs_write && !wait_r;
	assign ret_addr   = pc_r + bsc_pkg::PC_STEP;
	assign pop_ret    = {mem[idx(sp_r, 8'h00)], mem[idx(sp_r, 8'h01)]};
	assign pop_cc     = mem[idx(sp_r, 8'h00)];
	assign pop_exc_pc = {mem[idx(sp_r, 8'h02)], mem[idx(sp_r, 8'h03)]};

	// ==========================================================
	// Bus response
	// A write is held off while an instruction runs, so a new command or a
	// register update can never land in the middle of a block move.
	always_comb
	begin
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		if (wait_r && (avs_read || (avs_write && !busy)))
		begin
			wait_nxt  = 1'b0;
			rdata_nxt = '0;
			if (avs_read)
			begin
				case (avs_address)
					bsc_pkg::OFS_CMD:   rdata_nxt = {24'h0000_00, cond_r, op_r};
					bsc_pkg::OFS_OPND:  rdata_nxt = {16'h0000, opnd_r};
					bsc_pkg::OFS_PC:    rdata_nxt = {16'h0000, pc_r};
					bsc_pkg::OFS_SP:    rdata_nxt = {16'h0000, sp_r};
					bsc_pkg::OFS_CC:    rdata_nxt = {24'h0000_00, cc_r};
					bsc_pkg::OFS_GREG:  rdata_nxt = {24'h0000_00, greg_r};
					bsc_pkg::OFS_COUNT: rdata_nxt = {24'h0000_00, cnt_r};
					bsc_pkg::OFS_SRC:   rdata_nxt = {16'h0000, src_r};
					bsc_pkg::OFS_DST:   rdata_nxt = {16'h0000, dst_r};
					bsc_pkg::OFS_MADDR: rdata_nxt = {24'h0000_00, maddr_r};
					bsc_pkg::OFS_MDATA: rdata_nxt = {24'h0000_00, mem[maddr_r]};
					bsc_pkg::OFS_STAT:  rdata_nxt = {28'h000_0000, pmode_r, pdown_r, busy};
					bsc_pkg::OFS_PDCFG: rdata_nxt = {30'h0000_0000, pcfg_r};
					default:            rdata_nxt = '0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wait_r  <= 1'b1;
			rdata_r <= '0;
		end
		else
		begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;

	// ==========================================================
	// Execution
	always_comb
	begin
		state_nxt = state_r;
		op_nxt    = op_r;
		cond_nxt  = cond_r;
		opnd_nxt  = opnd_r;
		pc_nxt    = pc_r;
		sp_nxt    = sp_r;
		cc_nxt    = cc_r;
		greg_nxt  = greg_r;
		cnt_nxt   = cnt_r;
		src_nxt   = src_r;
		dst_nxt   = dst_r;
		maddr_nxt = maddr_r;
		lo_nxt    = lo_r;
		pdown_nxt = pdown_r;
		pmode_nxt = pmode_r;
		pcfg_nxt  = pcfg_r;
		mem_we    = 1'b0;
		mem_wa    = maddr_r;
		mem_wd    = avs_writedata[7:0];
		if (wr_do && avs_byteenable[0])
		begin
			case (avs_address)
				bsc_pkg::OFS_CMD:
				begin
					// Commands are ignored while powered down.
					if (state_r == bsc_pkg::S_IDLE)
					begin
						op_nxt    = avs_writedata[bsc_pkg::CMD_OP_LSB +: 4];
						cond_nxt  = avs_writedata[bsc_pkg::CMD_COND_LSB +: 4];
						state_nxt = bsc_pkg::S_EXEC;
					end
				end
				bsc_pkg::OFS_STAT:
				begin
					if (state_r == bsc_pkg::S_SLEEP && avs_writedata[bsc_pkg::ST_PDOWN])
					begin
						pdown_nxt = 1'b0;
						state_nxt = bsc_pkg::S_IDLE;
					end
				end
				bsc_pkg::OFS_MDATA: mem_we = 1'b1;
				default:            ;
			endcase
		end
		if (wr_do)
		begin
			case (avs_address)
				bsc_pkg::OFS_OPND:  opnd_nxt  = merge16(opnd_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_PC:    pc_nxt    = merge16(pc_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_SP:    sp_nxt    = merge16(sp_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_CC:    cc_nxt    = merge8(cc_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_GREG:  greg_nxt  = merge8(greg_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_COUNT: cnt_nxt   = merge8(cnt_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_SRC:   src_nxt   = merge16(src_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_DST:   dst_nxt   = merge16(dst_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_MADDR: maddr_nxt = merge8(maddr_r, avs_writedata, avs_byteenable);
				bsc_pkg::OFS_PDCFG: pcfg_nxt  = avs_byteenable[0] ? avs_writedata[1:0] : pcfg_r;
				default:            ;
			endcase
		end
		case (state_r)
			bsc_pkg::S_IDLE:  ;
			bsc_pkg::S_SLEEP: ;
			bsc_pkg::S_EXEC:
			begin
				state_nxt = bsc_pkg::S_IDLE;
				pc_nxt    = ret_addr;
				case (op_r)
					bsc_pkg::OP_BCC:  pc_nxt = cond_true ? opnd_r : ret_addr;
					bsc_pkg::OP_JMP:  pc_nxt = opnd_r;
					bsc_pkg::OP_BSR, bsc_pkg::OP_JSR:
					begin
						// The high byte goes out now, the low byte on the next cycle.
						pc_nxt    = (op_r == bsc_pkg::OP_BSR) ? ret_addr + {{8{opnd_r[7]}}, opnd_r[7:0]} : opnd_r;
						sp_nxt    = sp_r - bsc_pkg::RET_BYTES;
						mem_we    = 1'b1;
						mem_wa    = idx(sp_r, 8'hfe);
						mem_wd    = ret_addr[15:8];
						lo_nxt    = ret_addr[7:0];
						state_nxt = bsc_pkg::S_PUSH;
					end
					bsc_pkg::OP_RET:
					begin
						pc_nxt = pop_ret;
						sp_nxt = sp_r + bsc_pkg::RET_BYTES;
					end
					bsc_pkg::OP_RTE:
					begin
						cc_nxt = pop_cc;
						pc_nxt = pop_exc_pc;
						sp_nxt = sp_r + bsc_pkg::EXC_BYTES;
					end
					bsc_pkg::OP_SLEEP:
					begin
						pdown_nxt = 1'b1;
						pmode_nxt = pcfg_r;
						state_nxt = bsc_pkg::S_SLEEP;
					end
					bsc_pkg::OP_LDCI: cc_nxt   = opnd_r[7:0];
					bsc_pkg::OP_LDCR: cc_nxt   = greg_r;
					bsc_pkg::OP_STC:  greg_nxt = cc_r;
					bsc_pkg::OP_FLAGS_AND_IMM: cc_nxt   = cc_r & opnd_r[7:0];
					bsc_pkg::OP_ORC:  cc_nxt   = cc_r | opnd_r[7:0];
					bsc_pkg::OP_FLAGS_XOR_IMM: cc_nxt   = cc_r ^ opnd_r[7:0];
					bsc_pkg::OP_MOVE:
					begin
						// A zero count moves nothing and finishes at once.
						if (cnt_r != 8'h00)
						begin
							pc_nxt    = pc_r;
							state_nxt = bsc_pkg::S_MOVE;
						end
					end
					default: ;
				endcase
			end
			bsc_pkg::S_PUSH:
			begin
				mem_we    = 1'b1;
				mem_wa    = idx(sp_r, 8'h01);
				mem_wd    = lo_r;
				state_nxt = bsc_pkg::S_IDLE;
			end
			bsc_pkg::S_MOVE:
			begin
				// One byte per cycle; the program counter moves on only after the last byte.
				mem_we  = 1'b1;
				mem_wa  = dst_r[7:0];
				mem_wd  = mem[src_r[7:0]];
				src_nxt = src_r + 16'h0001;
				dst_nxt = dst_r + 16'h0001;
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01)
				begin
					pc_nxt    = ret_addr;
					state_nxt = bsc_pkg::S_IDLE;
				end
			end
			default: state_nxt = bsc_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_r <= bsc_pkg::S_IDLE;
			op_r    <= bsc_pkg::OP_NOP;
			cond_r  <= bsc_pkg::CND_ALWAYS;
			opnd_r  <= '0;
			pc_r    <= bsc_pkg::PC_RST;
			sp_r    <= bsc_pkg::SP_RST;
			cc_r    <= bsc_pkg::CC_RST;
			greg_r  <= '0;
			cnt_r   <= '0;
			src_r   <= '0;
			dst_r   <= '0;
			maddr_r <= '0;
			lo_r    <= '0;
			pdown_r <= 1'b0;
			pmode_r <= '0;
			pcfg_r  <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			op_r    <= op_nxt;
			cond_r  <= cond_nxt;
			opnd_r  <= opnd_nxt;
			pc_r    <= pc_nxt;
			sp_r    <= sp_nxt;
			cc_r    <= cc_nxt;
			greg_r  <= greg_nxt;
			cnt_r   <= cnt_nxt;
			src_r   <= src_nxt;
			dst_r   <= dst_nxt;
			maddr_r <= maddr_nxt;
			lo_r    <= lo_nxt;
			pdown_r <= pdown_nxt;
			pmode_r <= pmode_nxt;
			pcfg_r  <= pcfg_nxt;
		end
	end

	// The scratch memory holds no reset so it can map onto plain RAM.
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
		begin
			mem[mem_wa] <= mem_wd;
		end
	end

	assign power_down      = pdown_r;
	assign power_down_mode = pmode_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic ex_v;
	assign ex_v = (state_r == bsc_pkg::S_EXEC);

	a_branch_target: assert property (ex_v && op_r == bsc_pkg::OP_BCC |=>
		pc_r == ($past(cond_true) ? $past(opnd_r) : $past(pc_r) + bsc_pkg::PC_STEP))
		else $error("branch did not follow its condition");
	a_cond_higher: assert property (cond_r == bsc_pkg::CND_HI |->
		cond_true == !(cc_r[bsc_pkg::CC_C] | cc_r[bsc_pkg::CC_Z]))
		else $error("higher test wrong");
	a_jump_target: assert property (ex_v && op_r == bsc_pkg::OP_JMP |=> pc_r == $past(opnd_r))
		else $error("jump missed its target");
	a_call_frame: assert property (ex_v && op_r == bsc_pkg::OP_JSR |=> state_r == bsc_pkg::S_PUSH
		##1 pop_ret == $past(pc_r, 2) + bsc_pkg::PC_STEP && pc_r == $past(opnd_r, 2))
		else $error("call frame wrong");
	a_return_pop: assert property (ex_v && op_r == bsc_pkg::OP_RET |=>
		pc_r == $past(pop_ret) && sp_r == $past(sp_r) + bsc_pkg::RET_BYTES)
		else $error("return did not pop");
	a_exc_restore: assert property (ex_v && op_r == bsc_pkg::OP_RTE |=>
		cc_r == $past(pop_cc) && pc_r == $past(pop_exc_pc) && sp_r == $past(sp_r) + bsc_pkg::EXC_BYTES)
		else $error("exception return did not restore");
	a_sleep_enter: assert property (ex_v && op_r == bsc_pkg::OP_SLEEP |=>
		power_down && power_down_mode == $past(pcfg_r) && state_r == bsc_pkg::S_SLEEP)
		else $error("power-down not entered");
	a_flags_load: assert property (ex_v && op_r == bsc_pkg::OP_LDCR |=> cc_r == $past(greg_r))
		else $error("flag load wrong");
	a_flags_store: assert property (ex_v && op_r == bsc_pkg::OP_STC |=> greg_r == $past(cc_r))
		else $error("flag store wrong");
	a_flags_and: assert property (ex_v && op_r == bsc_pkg::OP_FLAGS_AND_IMM |=> cc_r == ($past(cc_r) & $past(opnd_r[7:0])))
		else $error("flag AND wrong");
	a_flags_or: assert property (ex_v && op_r == bsc_pkg::OP_ORC |=> cc_r == ($past(cc_r) | $past(opnd_r[7:0])))
		else $error("flag OR wrong");
	a_flags_xor: assert property (ex_v && op_r == bsc_pkg::OP_FLAGS_XOR_IMM |=> cc_r == ($past(cc_r) ^ $past(opnd_r[7:0])))
		else $error("flag XOR wrong");
	a_nop_only: assert property (ex_v && op_r == bsc_pkg::OP_NOP |=> pc_r == $past(pc_r) + bsc_pkg::PC_STEP
		&& $stable(cc_r) && $stable(sp_r) && $stable(greg_r))
		else $error("no-operation changed state");
	a_move_step: assert property (state_r == bsc_pkg::S_MOVE |=>
		cnt_r == $past(cnt_r) - 8'h01 && src_r == $past(src_r) + 16'h0001 && dst_r == $past(dst_r) + 16'h0001)
		else $error("block move step wrong");
	a_move_zero: assert property (ex_v && op_r == bsc_pkg::OP_MOVE && cnt_r == 8'h00 |=>
		state_r == bsc_pkg::S_IDLE && cnt_r == 8'h00)
		else $error("zero count moved data");
	a_move_stall: assert property (state_r == bsc_pkg::S_MOVE |-> avs_waitrequest || !avs_write)
		else $error("write accepted during block move");

endmodule

// File: inc/bsc_pkg.sv
// Constants, register map and state encoding for the branch and system control execution unit.
// Assumes one 100 MHz clock and a 32-bit Avalon-MM slave port with byte addresses.
package bsc_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned BUS_AW    = 8;
	localparam int unsigned BUS_DW    = 32;
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned MEM_DEPTH = 256;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CMD   = 8'h00;
	localparam logic [7:0] OFS_OPND  = 8'h04;
	localparam logic [7:0] OFS_PC    = 8'h08;
	localparam logic [7:0] OFS_SP    = 8'h0c;
	localparam logic [7:0] OFS_CC    = 8'h10;
	localparam logic [7:0] OFS_GREG  = 8'h14;
	localparam logic [7:0] OFS_COUNT = 8'h18;
	localparam logic [7:0] OFS_SRC   = 8'h1c;
	localparam logic [7:0] OFS_DST   = 8'h20;
	localparam logic [7:0] OFS_MADDR = 8'h24;
	localparam logic [7:0] OFS_MDATA = 8'h28;
	localparam logic [7:0] OFS_STAT  = 8'h2c;
	localparam logic [7:0] OFS_PDCFG = 8'h30;

	// ==========================================================
	// Field positions
	localparam int unsigned CMD_OP_LSB   = 0;
	localparam int unsigned CMD_COND_LSB = 4;
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_PDOWN     = 1;
	localparam int unsigned ST_MODE_LSB  = 2;
	localparam int unsigned CC_C         = 0;
	localparam int unsigned CC_V         = 1;
	localparam int unsigned CC_Z         = 2;
	localparam int unsigned CC_N         = 3;

	// ==========================================================
	// Operation codes held in the command register
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_BCC   = 4'h1;
	localparam logic [3:0] OP_JMP   = 4'h2;
	localparam logic [3:0] OP_BSR   = 4'h3;
	localparam logic [3:0] OP_JSR   = 4'h4;
	localparam logic [3:0] OP_RET   = 4'h5;
	localparam logic [3:0] OP_RTE   = 4'h6;
	localparam logic [3:0] OP_SLEEP = 4'h7;
	localparam logic [3:0] OP_LDCI  = 4'h8;
	localparam logic [3:0] OP_LDCR  = 4'h9;
	localparam logic [3:0] OP_STC   = 4'ha;
	localparam logic [3:0] OP_FLAGS_AND_IMM  = 4'hb;
	localparam logic [3:0] OP_ORC   = 4'hc;
	localparam logic [3:0] OP_FLAGS_XOR_IMM  = 4'hd;
	localparam logic [3:0] OP_MOVE  = 4'he;

	// ==========================================================
	// Condition codes; an odd code is the inverse of the even code below it
	localparam logic [3:0] CND_ALWAYS = 4'h0;
	localparam logic [3:0] CND_HI     = 4'h2;
	localparam logic [3:0] CND_CC     = 4'h4;
	localparam logic [3:0] CND_NE     = 4'h6;
	localparam logic [3:0] CND_VC     = 4'h8;
	localparam logic [3:0] CND_PL     = 4'ha;
	localparam logic [3:0] CND_GE     = 4'hc;
	localparam logic [3:0] CND_GT     = 4'he;

	// ==========================================================
	// Reset values and steps
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam logic [15:0] SP_RST    = 16'h0000;
	localparam logic [7:0]  CC_RST    = 8'h00;
	localparam logic [15:0] PC_STEP   = 16'h0002;
	localparam logic [15:0] RET_BYTES = 16'h0002;
	localparam logic [15:0] EXC_BYTES = 16'h0004;

	// ==========================================================
	// Execution states, Gray coded along idle, exec, push, move
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_EXEC  = 3'h1,
		S_PUSH  = 3'h3,
		S_MOVE  = 3'h2,
		S_SLEEP = 3'h6
	} bsc_state_t;

endpackage

// File: verif/bsc_avs_host.sv
// Avalon-MM master model standing in for the software side of the execution unit.
// Assumes one clock and a slave that marks its answer by one cycle of waitrequest low.
`timescale 1ns/1ps
module bsc_avs_host
(
	// Clock
	input  wire logic        core_clk,
	// Avalon-MM master side
	output logic [7:0]  avs_address,
	output logic        avs_read,
	output logic        avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	// ==========================================================
	// Bus cycles
	initial
	begin
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hf;
	end

	// Released lines show the inverse of the last value so stale data never looks valid.
	task automatic xfer(input logic rnw, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= rnw;
		avs_write     <= ~rnw;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_address   <= ~a;
		avs_writedata <= ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b1, a, 32'h0000_0000, q);
	endtask
endmodule

// File: verif/bsc_exec_unit_bench.sv
// Self-checking bench for the execution unit, driving it through its register port.
// Assumes the host model in bsc_avs_host.sv and the register map of bsc_pkg.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bsc_exec_unit_bench;
	// ==========================================================
	// Signals
	logic        core_clk = 1'b0;
	logic        nrst     = 1'b0;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        power_down;
	logic [1:0]  power_down_mode;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          cyc        = 0;

	always #5 core_clk = ~core_clk;

	bsc_exec_unit dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_down(power_down),
		.power_down_mode(power_down_mode));

	bsc_avs_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ==========================================================
	// Helpers
	task automatic finish_test();
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A hang in the bus or a stuck busy flag ends here as a mismatch.
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		host.rd(a, q);
		`CHK(q, e)
	endtask

	task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(bsc_pkg::OFS_MADDR, {24'h00_0000, a});
		host.wr(bsc_pkg::OFS_MDATA, {24'h00_0000, d});
	endtask

	task automatic chk_mem(input logic [7:0] a, input logic [7:0] e);
		host.wr(bsc_pkg::OFS_MADDR, {24'h00_0000, a});
		chk_reg(bsc_pkg::OFS_MDATA, {24'h00_0000, e});
	endtask

	// Reads never stall, so completion is found by polling the busy bit.
	task automatic exec(input logic [3:0] op, input logic [3:0] cnd);
		logic [31:0] q;
		host.wr(bsc_pkg::OFS_CMD, {24'h00_0000, cnd, op});
		repeat (2) @(posedge core_clk);
		q = 32'h0000_0001;
		for (int i = 0; i < 40 && q[0] !== 1'b0; i++)
			host.rd(bsc_pkg::OFS_STAT, q);
		`CHK(q[0], 1'b0)
	endtask

	function automatic logic br_exp(input logic [3:0] c, input logic [3:0] f);
		logic t;
		case (c[3:1])
			3'h0: t = 1'b1;
			3'h1: t = ~(f[0] | f[2]);
			3'h2: t = ~f[0];
			3'h3: t = ~f[2];
			3'h4: t = ~f[1];
			3'h5: t = ~f[3];
			3'h6: t = ~(f[3] ^ f[1]);
			default: t = ~(f[2] | (f[3] ^ f[1]));
		endcase
		return t ^ c[0];
	endfunction

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0000);
		chk_reg(bsc_pkg::OFS_SP, 32'h0000_0000);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_0000);
		chk_reg(bsc_pkg::OFS_STAT, 32'h0000_0000);
		chk_reg(8'h3c, 32'h0000_0000);
	endtask

	task automatic t_branch();
		for (int f = 0; f < 16; f++)
			for (int c = 0; c < 16; c++)
			begin
				host.wr(bsc_pkg::OFS_CC, f);
				host.wr(bsc_pkg::OFS_PC, 32'h0000_0100);
				host.wr(bsc_pkg::OFS_OPND, 32'h0000_0200);
				exec(bsc_pkg::OP_BCC, c[3:0]);
				chk_reg(bsc_pkg::OFS_PC, br_exp(c[3:0], f[3:0]) ? 32'h0000_0200 : 32'h0000_0102);
			end
	endtask

	task automatic t_calls();
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_1234);
		exec(bsc_pkg::OP_JMP, bsc_pkg::CND_ALWAYS + 4'h1);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_1234);
		host.wr(bsc_pkg::OFS_PC, 32'h0000_0010);
		host.wr(bsc_pkg::OFS_SP, 32'h0000_0080);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_0040);
		exec(bsc_pkg::OP_JSR, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0040);
		chk_reg(bsc_pkg::OFS_SP, 32'h0000_007e);
		chk_mem(8'h7f, 8'h12);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_00fe);
		exec(bsc_pkg::OP_BSR, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0040);
		chk_mem(8'h7d, 8'h42);
		exec(bsc_pkg::OP_RET, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0042);
		exec(bsc_pkg::OP_RET, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0012);
		chk_reg(bsc_pkg::OFS_SP, 32'h0000_0080);
	endtask

	task automatic t_rte();
		host.wr(bsc_pkg::OFS_SP, 32'h0000_0090);
		mem_wr(8'h90, 8'ha5);
		mem_wr(8'h92, 8'h56);
		mem_wr(8'h93, 8'h78);
		exec(bsc_pkg::OP_RTE, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_00a5);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_5678);
		chk_reg(bsc_pkg::OFS_SP, 32'h0000_0094);
	endtask

	task automatic t_flags();
		host.wr(bsc_pkg::OFS_PC, 32'h0000_0300);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_005a);
		exec(bsc_pkg::OP_LDCI, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_005a);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_000f);
		exec(bsc_pkg::OP_FLAGS_AND_IMM, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_000a);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_0030);
		exec(bsc_pkg::OP_ORC, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_003a);
		host.wr(bsc_pkg::OFS_OPND, 32'h0000_00ff);
		exec(bsc_pkg::OP_FLAGS_XOR_IMM, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_00c5);
		exec(bsc_pkg::OP_STC, 4'h0);
		chk_reg(bsc_pkg::OFS_GREG, 32'h0000_00c5);
		host.wr(bsc_pkg::OFS_GREG, 32'h0000_0033);
		exec(bsc_pkg::OP_LDCR, 4'h0);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_0033);
		exec(bsc_pkg::OP_NOP, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_030e);
		chk_reg(bsc_pkg::OFS_CC, 32'h0000_0033);
		chk_reg(bsc_pkg::OFS_SP, 32'h0000_0094);
	endtask

	task automatic t_move();
		mem_wr(8'h10, 8'h11);
		mem_wr(8'h11, 8'h22);
		mem_wr(8'h12, 8'h33);
		mem_wr(8'h30, 8'h5a);
		host.wr(bsc_pkg::OFS_PC, 32'h0000_0400);
		host.wr(bsc_pkg::OFS_COUNT, 32'h0000_0003);
		host.wr(bsc_pkg::OFS_SRC, 32'h0000_0010);
		host.wr(bsc_pkg::OFS_DST, 32'h0000_0020);
		host.wr(bsc_pkg::OFS_CMD, {28'h000_0000, bsc_pkg::OP_MOVE});
		// Reads are answered mid-move, so busy must still show while bytes are copied.
		chk_reg(bsc_pkg::OFS_STAT, 32'h0000_0001);
		exec(bsc_pkg::OP_NOP, 4'h0);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0404);
		chk_mem(8'h20, 8'h11);
		chk_mem(8'h21, 8'h22);
		chk_mem(8'h22, 8'h33);
		chk_reg(bsc_pkg::OFS_SRC, 32'h0000_0013);
		chk_reg(bsc_pkg::OFS_DST, 32'h0000_0023);
		chk_reg(bsc_pkg::OFS_COUNT, 32'h0000_0000);
		host.wr(bsc_pkg::OFS_SRC, 32'h0000_0010);
		host.wr(bsc_pkg::OFS_DST, 32'h0000_0030);
		exec(bsc_pkg::OP_MOVE, 4'h0);
		chk_mem(8'h30, 8'h5a);
		chk_reg(bsc_pkg::OFS_SRC, 32'h0000_0010);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0406);
	endtask

	task automatic t_sleep();
		host.wr(bsc_pkg::OFS_PDCFG, 32'h0000_0002);
		exec(bsc_pkg::OP_SLEEP, 4'h0);
		`CHK(power_down, 1'b1)
		`CHK(power_down_mode, 2'h2)
		host.wr(bsc_pkg::OFS_CMD, {28'h000_0000, bsc_pkg::OP_NOP});
		repeat (3) @(posedge core_clk);
		chk_reg(bsc_pkg::OFS_PC, 32'h0000_0408);
		host.wr(bsc_pkg::OFS_STAT, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		`CHK(power_down, 1'b0)
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		`CHK(power_down, 1'b0)
		t_reset();
		t_branch();
		t_calls();
		t_rte();
		t_flags();
		t_move();
		t_sleep();
		finish_test();
	end
endmodule
